// ### design/wsp_top.sv
`timescale 1ns/1ps
`include "wsp_cfg.svh"

// What this block does and what its host must do
// R1: rising edge of reset pin loads wiper register with midscale
// R2: sixteen-bit shift register captures data on serial clock falling edges
// R3: host keeps serial clock at or below 50 MHz
// R4: frame select falling enables shifting on following clock falls only
// R5: frame select rise after sixteen clocks updates the addressed register
// R6: frame select rise before sixteen clocks aborts, nothing changes
// R7: serial output is open-drain, shifting out register contents
// R8: host provides pull-up on the serial output
// R9: completion flag rises when wiper read or write has executed
// R10: word is two zeros, four command bits, ten data bits, msb first
// R11: frames are whole multiples of sixteen bits
// R12: wiper writes blocked until enabled by control command; resets still work
// R13: serial output changes on serial clock rising edges
// R14: bit counter clears on each frame select falling edge
// R15: completion flag held low from frame end until command executed
module wsp_top
	import wsp_pkg::*;
#(
	parameter int DATA_W       = `WSP_DATA_W,
	parameter int RST_EXEC_CYC = `WSP_RST_EXEC_NS / `WSP_CLK_NS
)(
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              sclk,
	input  wire logic              sync_n,
	input  wire logic              din,
	input  wire logic              reset_pin,
	input  wire logic              serial_out_in,
	output logic                   serial_out_out,
	output logic                   serial_out_oe,
	input  wire logic              ready_in,
	output logic                   ready_out,
	output logic                   ready_oe,
	output logic      [DATA_W-1:0] wiper_position,
	output logic                   perf_mode,
	output logic                   shutdown
);

	localparam int FB     = `WSP_FRAME_BITS;
	localparam int CNT_W  = $clog2(RST_EXEC_CYC + 1);
	localparam int WR_CYC = `WSP_WR_EXEC_NS / `WSP_CLK_NS;
	localparam int RD_CYC = `WSP_RD_EXEC_NS / `WSP_CLK_NS;

	// ----------------------------------------
	// pin sampling and edge detection
	// ----------------------------------------
	logic [3:0]       pins;
	logic             sclk_q;
	logic             sync_q;
	logic             rpin_q;

	wsp_sync #(.W(4), .INIT(`WSP_PIN_IDLE)) u_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.d     ({sclk, sync_n, din, reset_pin}),
		.q     (pins)
	);

	wire sclk_s      = pins[`WSP_PIN_SCLK];
	wire sync_s      = pins[`WSP_PIN_SYNC];
	wire din_s       = pins[`WSP_PIN_DIN];
	wire rpin_s      = pins[`WSP_PIN_RST];
	wire sclk_rise   = sclk_s & ~sclk_q;
	wire sclk_fall   = ~sclk_s & sclk_q;
	wire in_frame    = ~sync_s;
	wire frame_start = ~sync_s & sync_q;
	wire frame_end   = sync_s & ~sync_q;
	wire rpin_rise   = rpin_s & ~rpin_q;
	wire shift_fall  = sclk_fall & in_frame;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q <= 1'(`WSP_PIN_IDLE >> `WSP_PIN_SCLK);
			sync_q <= 1'(`WSP_PIN_IDLE >> `WSP_PIN_SYNC);
			rpin_q <= 1'(`WSP_PIN_IDLE >> `WSP_PIN_RST);
		end else begin
			sclk_q <= sclk_s;
			sync_q <= sync_s;
			rpin_q <= rpin_s;
		end
	end

	// ----------------------------------------
	// shift register and bit counter
	// ----------------------------------------
	logic [FB-1:0]    sr;
	logic [3:0]       bit_cnt;
	logic             got16;
	logic             we;
	logic [CNT_W-1:0] cnt;
	wsp_state_t       state;
	wsp_state_t       next_state;

	wire [3:0]        base_cnt     = frame_start ? 4'h0 : bit_cnt;
	wire [3:0]        next_bit_cnt = base_cnt + {3'h0, shift_fall};
	wire              next_got16   = (frame_start ? 1'b0 : got16)
		| (shift_fall & (base_cnt == 4'hf));
	// partial tail of an over-long frame also refuses the word
	wire              word_ok      = frame_end & got16 & (bit_cnt == 4'h0);
	wire [3:0]        cmd          = sr[`WSP_CMD_MSB:`WSP_CMD_LSB];
	wire [DATA_W-1:0] data         = sr[DATA_W-1:0];
	wire              is_wr        = cmd == `WSP_CMD_WR;
	wire              is_rd        = cmd == `WSP_CMD_RD;
	wire              is_rst       = cmd == `WSP_CMD_RST;
	wire              is_ctrl      = cmd == `WSP_CMD_CTRL;
	wire              is_rdctrl    = cmd == `WSP_CMD_RDCTRL;
	wire              is_shdn      = cmd == `WSP_CMD_SHDN;
	wire [FB-1:0]     ctrl_word    = {{(FB-3){1'b0}}, perf_mode, we, shutdown};
	wire [FB-1:0]     rd_word      = {`WSP_ZERO_PAD, wiper_position};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt <= 4'h0;
			got16   <= 1'b0;
		end else begin
			bit_cnt <= next_bit_cnt;  // see R14, see R11
			got16   <= next_got16;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sr <= '0;
		end else if (shift_fall) begin
			sr <= {sr[FB-2:0], din_s};  // see R2, see R4, see R10
		end else if (word_ok && is_rd) begin
			sr <= rd_word;
		end else if (word_ok && is_rdctrl) begin
			sr <= ctrl_word;
		end
	end

	// ----------------------------------------
	// open-drain serial output
	// ----------------------------------------
	// never driven high: the pad only pulls low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_out_out <= 1'b0;
			serial_out_oe  <= 1'b0;
		end else begin
			serial_out_out <= 1'b0;  // see R7, see R8
			if (frame_end)
				serial_out_oe <= 1'b0;
			else if (sclk_rise && in_frame)
				serial_out_oe <= ~sr[`WSP_OUT_MSB];  // see R13
		end
	end

	// ----------------------------------------
	// register updates at frame end and on reset pin rise
	// ----------------------------------------
	wire soft_rst = word_ok & is_rst;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wiper_position <= `WSP_MIDSCALE;
		end else if (rpin_rise || soft_rst) begin
			wiper_position <= `WSP_MIDSCALE;  // see R1, see R12
		end else if (word_ok && is_wr && we) begin
			wiper_position <= data;  // see R5, see R6, see R12
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			we        <= 1'b0;
			perf_mode <= 1'b0;
			shutdown  <= 1'b0;
		end else if (soft_rst) begin
			we        <= 1'b0;
			perf_mode <= 1'b0;
			shutdown  <= 1'b0;
		end else if (word_ok && is_ctrl) begin
			we        <= sr[`WSP_BIT_WE];  // see R12
			perf_mode <= sr[`WSP_BIT_PERF];
		end else if (word_ok && is_shdn) begin
			shutdown  <= sr[`WSP_BIT_SHDN];
		end
	end

	// ----------------------------------------
	// execution timer and completion flag
	// ----------------------------------------
	wire              start_exec = rpin_rise | (word_ok & (is_wr | is_rd | is_rst));
	wire [CNT_W-1:0]  exec_len   = (rpin_rise | is_rst) ? CNT_W'(RST_EXEC_CYC - 1) :
		is_rd ? CNT_W'(RD_CYC - 1) : CNT_W'(WR_CYC - 1);
	wire              cnt_done   = cnt == '0;

	always_comb begin
		next_state = state;
		if (start_exec)
			next_state = wsp_exec;
		else if (state == wsp_exec && cnt_done)
			next_state = wsp_idle;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= wsp_idle;
			cnt   <= '0;
		end else begin
			state <= next_state;
			if (start_exec)
				cnt <= exec_len;
			else if (!cnt_done)
				cnt <= cnt - 1'b1;
		end
	end

	// flag low while executing, released when done
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready_out <= 1'b0;
			ready_oe  <= 1'b0;
		end else begin
			ready_out <= 1'b0;
			ready_oe  <= next_state == wsp_exec;  // see R9, see R15
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_wr_end;
		word_ok && is_wr && !rpin_rise;
	endsequence

	sequence s_rd_end;
		word_ok && is_rd && !rpin_rise;
	endsequence

	sequence s_no_start;
		!start_exec;
	endsequence

	a_reset_midscale: assert property ( // see R1
		rpin_rise |=> wiper_position == `WSP_MIDSCALE)
		else $error("wiper not midscale after reset pin");

	a_shift_capture: assert property ( // see R2
		shift_fall |=> sr[0] == $past(din_s) && sr[FB-1:1] == $past(sr[FB-2:0]))
		else $error("serial bit not captured");

	a_frame_clear: assert property ( // see R14
		frame_start && !shift_fall |=> bit_cnt == 4'h0 && !got16)
		else $error("bit counter not cleared");

	a_abort_hold: assert property ( // see R6
		frame_end && !got16 && !rpin_rise |=> $stable(wiper_position) && $stable(we))
		else $error("aborted frame changed state");

	a_write_apply: assert property ( // see R5
		s_wr_end ##0 we |=> wiper_position == $past(data))
		else $error("enabled write not applied");

	a_write_block: assert property ( // see R12
		s_wr_end ##0 !we |=> $stable(wiper_position))
		else $error("write applied while protected");

	a_write_busy: assert property ( // see R15
		s_wr_end |=> (ready_oe && !start_exec) [*8] ##1 !ready_oe)
		else $error("write busy time wrong");

	a_read_busy: assert property ( // see R9
		s_rd_end ##1 s_no_start [*8] ##1 s_no_start |-> ready_oe ##1 !ready_oe)
		else $error("flag not released after read");

	a_so_rising: assert property ( // see R13
		sclk_rise && in_frame |=> serial_out_oe == !$past(sr[`WSP_OUT_MSB]))
		else $error("serial output not updated on rise");

	a_odd_length: assert property ( // see R11
		frame_end && bit_cnt != 4'h0 && !rpin_rise |=> $stable(wiper_position))
		else $error("odd length frame accepted");

endmodule

// ### design/wsp_cfg.svh
`ifndef WSP_CFG_SVH
`define WSP_CFG_SVH

// ----------------------------------------
// frame layout
// ----------------------------------------
`define WSP_FRAME_BITS  16
`define WSP_DATA_W      10
`define WSP_CMD_MSB     13
`define WSP_CMD_LSB     10
`define WSP_OUT_MSB     15
`define WSP_MIDSCALE    10'h200
`define WSP_ZERO_PAD    6'h00

// ----------------------------------------
// command codes
// ----------------------------------------
`define WSP_CMD_NOP     4'h0
`define WSP_CMD_WR      4'h1
`define WSP_CMD_RD      4'h2
`define WSP_CMD_RST     4'h4
`define WSP_CMD_CTRL    4'h6
`define WSP_CMD_RDCTRL  4'h7
`define WSP_CMD_SHDN    4'h8

// ----------------------------------------
// control word fields
// ----------------------------------------
`define WSP_BIT_SHDN    0
`define WSP_BIT_WE      1
`define WSP_BIT_PERF    2

// ----------------------------------------
// pin idle levels {sclk, sync_n, din, reset_pin}
// ----------------------------------------
`define WSP_PIN_IDLE    4'h5
`define WSP_PIN_SCLK    3
`define WSP_PIN_SYNC    2
`define WSP_PIN_DIN     1
`define WSP_PIN_RST     0

// ----------------------------------------
// timing
// ----------------------------------------
`define WSP_CLK_NS      50
`define WSP_WR_EXEC_NS  410
`define WSP_RD_EXEC_NS  450
`define WSP_RST_EXEC_NS 1500000

`endif

// ### design/wsp_pkg.sv
package wsp_pkg;

	typedef enum logic [0:0] {
		wsp_idle,
		wsp_exec
	} wsp_state_t;

endpackage

// ### design/wsp_sync.sv
`timescale 1ns/1ps

module wsp_sync
	import wsp_pkg::*;
#(
	parameter int               W    = 4,
	parameter logic [W-1:0]     INIT = '0
)(
	input  wire logic           clk,
	input  wire logic           rst_n,
	input  wire logic [W-1:0]   d,
	output logic      [W-1:0]   q
);

	logic [W-1:0] meta;

	// first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					meta[i] <= INIT[i];
					q[i]    <= INIT[i];
				end else begin
					meta[i] <= d[i];
					q[i]    <= meta[i];
				end
			end
		end
	endgenerate

endmodule

// ### testbench/wsp_host.sv
`timescale 1ns/1ps

// ----------------------------------------
// serial host, clock idle low outside frames
// ----------------------------------------
module wsp_host(
	input  wire logic clk,
	input  wire logic so,
	output logic      sclk,
	output logic      sync_n,
	output logic      din
);
	initial begin
		sclk = 1'b0;
		sync_n = 1'b1;
		din = 1'b0;
	end

	// bits change on rise, readback sampled on fall
	task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] q);
		q = '0;
		@(posedge clk) sync_n <= 1'b0;
		repeat (2) @(posedge clk);
		for (int i = n - 1; i >= 0; i--) begin
			sclk <= 1'b1;
			din <= d[i];
			repeat (4) @(posedge clk);
			sclk <= 1'b0;
			q = {q[30:0], so};
			repeat (4) @(posedge clk);
		end
		sync_n <= 1'b1;
		// released line: do not leave last bit showing
		din <= ~din;
		repeat (6) @(posedge clk);
	endtask
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
`include "wsp_cfg.svh"

module testbench
	import wsp_pkg::*;
;
	localparam int RST_CYC = 20;
	logic        clk;
	logic        rst_n = 1'b0;
	logic        reset_pin = 1'b1;
	logic        sclk;
	logic        sync_n;
	logic        din;
	logic        so_oe;
	logic        so_out;
	logic        rdy_oe;
	logic        rdy_out;
	logic [9:0]  wiper;
	logic        perf;
	logic        shdn;
	logic [31:0] q;
	int          mismatches = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          lowcnt = 0;
	int          base;
	// pull-ups on both open-drain lines
	wire         so_pin = so_oe ? so_out : 1'b1;
	wire         rdy_pin = rdy_oe ? rdy_out : 1'b1;

	wsp_top #(.RST_EXEC_CYC(RST_CYC)) u_dut (
		.clk           (clk),
		.rst_n         (rst_n),
		.sclk          (sclk),
		.sync_n        (sync_n),
		.din           (din),
		.reset_pin     (reset_pin),
		.serial_out_in (so_pin),
		.serial_out_out(so_out),
		.serial_out_oe (so_oe),
		.ready_in      (rdy_pin),
		.ready_out     (rdy_out),
		.ready_oe      (rdy_oe),
		.wiper_position(wiper),
		.perf_mode     (perf),
		.shutdown      (shdn)
	);

	wsp_host u_host (
		.clk   (clk),
		.so    (so_pin),
		.sclk  (sclk),
		.sync_n(sync_n),
		.din   (din)
	);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (rdy_pin !== 1'b1)
			lowcnt <= lowcnt + 1;
		if (cyc == 20000) begin
			mismatches++;
			test_done();
		end
	end

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one frame, then busy time checked unless busy < 0
	task automatic cmd(input int n, input logic [31:0] d, input int busy);
		base = lowcnt;
		u_host.xfer(n, d, q);
		repeat (30) @(posedge clk);
		if (busy >= 0)
			chk(lowcnt - base, busy);
	endtask

	task automatic t_reset;
		chk(wiper, `WSP_MIDSCALE);
		chk({perf, shdn, so_pin, rdy_pin}, 4'h3);
		chk({so_out, rdy_out}, 2'h0);
	endtask

	task automatic t_protect;
		cmd(16, 16'h0555, 8);
		chk(wiper, `WSP_MIDSCALE);
	endtask

	task automatic t_enable;
		cmd(16, 16'h1806, -1);
		chk(perf, 1'b1);
		cmd(16, 16'h0555, 8);
		chk(wiper, 10'h155);
	endtask

	task automatic t_abort;
		cmd(15, 16'h03FF, 0);
		chk(wiper, 10'h155);
		cmd(16, 16'h04AA, 8);
		chk(wiper, 10'h0AA);
	endtask

	task automatic t_read;
		cmd(16, 16'h0800, 9);
		cmd(16, 16'h0000, -1);
		chk(q, 32'h0000_00AA);
	endtask

	task automatic t_chain;
		cmd(32, 32'h0412_07FF, 8);
		chk(wiper, 10'h3FF);
		chk(q, 32'h0000_0412);
	endtask

	task automatic t_ctrl;
		cmd(16, 16'h1C00, -1);
		cmd(16, 16'h2001, -1);
		chk(q, 32'h0000_0006);
		chk(shdn, 1'b1);
	endtask

	task automatic t_soft;
		cmd(16, 16'h1000, RST_CYC);
		chk({wiper, perf, shdn}, {`WSP_MIDSCALE, 2'b00});
		cmd(16, 16'h0555, 8);
		chk(wiper, `WSP_MIDSCALE);
	endtask

	task automatic t_pin;
		cmd(16, 16'h1802, -1);
		cmd(16, 16'h0555, 8);
		base = lowcnt;
		@(posedge clk) reset_pin <= 1'b0;
		repeat (8) @(posedge clk);
		chk(wiper, 10'h155);
		reset_pin <= 1'b1;
		repeat (30) @(posedge clk);
		chk(wiper, `WSP_MIDSCALE);
		chk(lowcnt - base, RST_CYC);
	endtask

	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_protect();
		t_enable();
		t_abort();
		t_read();
		t_chain();
		t_ctrl();
		t_soft();
		t_pin();
		test_done();
	end
endmodule
